/* hdl/gpx_port.sv */
// eight pin gpio port with alternate functions and external interrupts
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "gpx_consts.svh"
module gpx_port
  import gpx_pkg::*;
#(
  parameter logic [`GPX_PIN_W-1:0] IRQ_PU_MASK = `GPX_IRQ_PU_DEF, // irq pins with pull-up
  parameter logic [`GPX_PIN_W-1:0] IRQ_FLT_MASK = `GPX_IRQ_FLT_DEF, // irq pins without pull-up
  parameter logic [`GPX_PIN_W-1:0] TOD_MASK = `GPX_TOD_DEF // true open drain pins
)
(
  input wire logic core_clk, // cpu clock, 25 MHz
  input wire logic nrst, // sync reset, low
  input wire logic clk_en, // freezes all state when low
  input wire gpx_bus_req_t bus_req, // register access request
  output logic [`GPX_PIN_W-1:0] rd_data, // read data, cycle after strobe
  input wire logic [`GPX_PIN_W-1:0] pin_in, // pad input levels
  output gpx_pad_t pad, // pad drive, enable and pull-up
  input wire gpx_alt_t alt, // peripheral claims of the pins
  output logic [`GPX_PIN_W-1:0] alt_in, // level fed to peripheral inputs
  input wire logic vec_fetch, // cpu fetches this port's vector
  input wire logic cc_irq_mask, // cpu interrupt mask, high masks
  output logic irq_req, // external interrupt request
  output logic wake // wake from wait or halt
);
  gpx_port_st_t st_ff;
  gpx_port_st_t nxt_st;
  logic [`GPX_PIN_W-1:0] event_hit;
  logic [`GPX_PIN_W-1:0] irq_pin_en;
  logic wr_data;
  logic wr_dir;
  logic wr_opt;
  logic wr_sens;
  logic any_event;

  // pins that can ever be interrupt inputs
  localparam logic [`GPX_PIN_W-1:0] IRQ_CAP = IRQ_PU_MASK | IRQ_FLT_MASK;
  // pins whose pad carries a pull-up resistor
  localparam logic [`GPX_PIN_W-1:0] PU_CAP = ~IRQ_FLT_MASK & ~TOD_MASK;

  // driving pins: own output mode or a peripheral driving
  function automatic logic [`GPX_PIN_W-1:0] drive_mask(
    input logic [`GPX_PIN_W-1:0] dir,
    input logic [`GPX_PIN_W-1:0] alt_en
  );
    drive_mask = dir | alt_en;
  endfunction

  // value presented on driving pins
  function automatic logic [`GPX_PIN_W-1:0] drive_val(
    input logic [`GPX_PIN_W-1:0] latch,
    input gpx_alt_t a
  );
    drive_val = (a.en & a.out) | (~a.en & latch);
  endfunction

  // push-pull selection: peripheral wish wins over option bit
  function automatic logic [`GPX_PIN_W-1:0] push_pull(
    input logic [`GPX_PIN_W-1:0] opt,
    input gpx_alt_t a
  );
    push_pull = ((a.en & ~a.od) | (~a.en & opt)) & ~TOD_MASK;
  endfunction

  // data register read view, per pin
  function automatic logic [`GPX_PIN_W-1:0] data_view(
    input logic [`GPX_PIN_W-1:0] latch,
    input logic [`GPX_PIN_W-1:0] dir,
    input gpx_alt_t a,
    input logic [`GPX_PIN_W-1:0] pins
  );
    logic [`GPX_PIN_W-1:0] in_mode;
    in_mode = ~dir;
    // input with alternate output reads the peripheral's value
    data_view = (in_mode & a.en & a.out)
      | (in_mode & ~a.en & pins)
      | (dir & latch);
  endfunction

  // bus write decode
  always_comb begin
    wr_data = 1'b0;
    wr_dir = 1'b0;
    wr_opt = 1'b0;
    wr_sens = 1'b0;
    if (bus_req.wr) begin
      if (bus_req.addr == `GPX_OFF_DATA) begin
        wr_data = 1'b1;
      end else if (bus_req.addr == `GPX_OFF_DIR) begin
        wr_dir = 1'b1;
      end else if (bus_req.addr == `GPX_OFF_OPT) begin
        wr_opt = 1'b1;
      end else if (bus_req.addr == `GPX_OFF_SENS) begin
        wr_sens = 1'b1;
      end
    end
  end

  // interrupt input mode: input direction, option set, capable pin
  assign irq_pin_en = IRQ_CAP & ~st_ff.dir & st_ff.opt;
  // detected events of enabled pins merged into one request
  assign any_event = |(event_hit & irq_pin_en);

  gpx_irq_detect u_det (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin_in(pin_in),
    .sens(st_ff.sens),
    .event_hit(event_hit)
  );

  // next state of registers, request latch and registered outputs
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = `GPX_RD_IDLE;
    // whole byte writes; in input mode the latch changes, the pin not
    if (wr_data) begin
      nxt_st.latch = bus_req.wdata;
    end
    if (wr_dir) begin
      nxt_st.dir = bus_req.wdata;
    end
    if (wr_opt) begin
      nxt_st.opt = bus_req.wdata;
    end
    if (wr_sens) begin
      nxt_st.sens = gpx_sens_t'(bus_req.wdata[`GPX_SENS_W-1:0]);
    end
    // reads; the request latch has no address at all
    if (bus_req.rd) begin
      if (bus_req.addr == `GPX_OFF_DATA) begin
        nxt_st.rdata = data_view(st_ff.latch, st_ff.dir, alt, pin_in);
      end else if (bus_req.addr == `GPX_OFF_DIR) begin
        nxt_st.rdata = st_ff.dir;
      end else if (bus_req.addr == `GPX_OFF_OPT) begin
        nxt_st.rdata = st_ff.opt;
      end else if (bus_req.addr == `GPX_OFF_SENS) begin
        nxt_st.rdata = {{(`GPX_PIN_W-`GPX_SENS_W){1'b0}}, st_ff.sens};
      end else begin
        nxt_st.rdata = `GPX_RD_IDLE;
      end
    end
    // request latch: fetch or sensitivity write clears, a new event wins
    nxt_st.pend = (st_ff.pend & ~vec_fetch & ~wr_sens) | any_event;
    // cpu sees the request only while its mask is clear
    nxt_st.irq_req = nxt_st.pend & ~cc_irq_mask;
    // wake is independent of power state; the port itself never sleeps
    nxt_st.wake = nxt_st.pend;
    // pad drive follows the new settings so outputs stay registered
    nxt_st.pad.out = drive_val(nxt_st.latch, alt);
    nxt_st.pad.oe_n = ~(drive_mask(nxt_st.dir, alt.en)
      & (~nxt_st.pad.out | push_pull(nxt_st.opt, alt)));
    // pull-up only for input with option set on pull-up capable pads
    nxt_st.pad.pu = ~drive_mask(nxt_st.dir, alt.en) & nxt_st.opt & PU_CAP;
    // peripheral inputs see the latch on own outputs, else the pin
    nxt_st.alt_in = (nxt_st.dir & ~alt.en & nxt_st.latch)
      | (~(nxt_st.dir & ~alt.en) & pin_in);
  end

  // single state register; clock enable holds everything
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff.latch <= `GPX_RST_BYTE;
      st_ff.dir <= `GPX_RST_BYTE;
      st_ff.opt <= `GPX_RST_BYTE;
      st_ff.sens <= GPX_SENS_FALL_LOW;
      st_ff.pend <= 1'b0;
      st_ff.rdata <= `GPX_RD_IDLE;
      st_ff.pad.out <= `GPX_RST_BYTE;
      st_ff.pad.oe_n <= '1;
      st_ff.pad.pu <= `GPX_RST_BYTE;
      st_ff.alt_in <= `GPX_RST_BYTE;
      st_ff.irq_req <= 1'b0;
      st_ff.wake <= 1'b0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign rd_data = st_ff.rdata;
  assign pad = st_ff.pad;
  assign alt_in = st_ff.alt_in;
  assign irq_req = st_ff.irq_req;
  assign wake = st_ff.wake;
endmodule
`default_nettype wire

/* hdl/gpx_consts.svh */
// constants of the gpio port with external interrupts
// Notes on behaviour
// - every interrupt input pin feeds one shared request, sensitivity set by control bits.
// - each enabled pin is detected with the sensitivity, then all are ORed.
// - the request latch is hidden from software and clears on vector fetch.
// - writing the sensitivity control clears a pending request.
// - output mode drives the latch onto the pin; reads return the latch.
// - option picks push-pull or open-drain; zero drives low, one high or floats.
// - an enabled alternate function overrides direction and option settings.
// - a peripheral driving a pin forces output, drive type as the peripheral asks.
// - pin feeding a peripheral is input; data reads still return the pin level.
// - input pin with alternate output enabled reads back the alternate output.
// - output pin with alternate input reads the data latch into the peripheral.
// - wait and halt leave the port alone; external interrupts wake the device.
// - request reaches the cpu only for interrupt input mode and mask clear.
// - standard pins: 00 floating, 01 pull-up, 10 open drain, 11 push-pull.
// - pull-up interrupt pins: direction 0 option 1 is pull-up interrupt input.
// - floating interrupt pins: direction 0 option 1 is floating interrupt input.
// - pull-up only in pull-up input, high driver only in push-pull output.
// - bit x of the data, direction and option registers belongs to pin x.
// - input mode data reads return the live pin level.
// - input mode data writes update the latch only.
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH
`define GPX_PIN_W 8
`define GPX_ADDR_W 8
`define GPX_SENS_W 2
`define GPX_OFF_DATA 8'h00
`define GPX_OFF_DIR 8'h01
`define GPX_OFF_OPT 8'h02
`define GPX_OFF_SENS 8'h03
`define GPX_RST_BYTE 8'h00
`define GPX_RD_IDLE 8'h00
`define GPX_IRQ_PU_DEF 8'h48
`define GPX_IRQ_FLT_DEF 8'hA0
`define GPX_TOD_DEF 8'h00
`endif

/* hdl/gpx_pkg.sv */
// types shared by the gpio port modules
`include "gpx_consts.svh"
package gpx_pkg;
  // sensitivity modes, in code order 0..3
  typedef enum logic [`GPX_SENS_W-1:0] {
    GPX_SENS_FALL_LOW,
    GPX_SENS_RISE,
    GPX_SENS_FALL,
    GPX_SENS_BOTH
  } gpx_sens_t;
  typedef struct packed {
    logic [`GPX_ADDR_W-1:0] addr;
    logic [`GPX_PIN_W-1:0] wdata;
    logic wr;
    logic rd;
  } gpx_bus_req_t;
  typedef struct packed {
    logic [`GPX_PIN_W-1:0] en;
    logic [`GPX_PIN_W-1:0] out;
    logic [`GPX_PIN_W-1:0] od;
  } gpx_alt_t;
  typedef struct packed {
    logic [`GPX_PIN_W-1:0] out;
    logic [`GPX_PIN_W-1:0] oe_n;
    logic [`GPX_PIN_W-1:0] pu;
  } gpx_pad_t;
  typedef struct packed {
    logic [`GPX_PIN_W-1:0] sync_a;
    logic [`GPX_PIN_W-1:0] sync_b;
    logic [`GPX_PIN_W-1:0] prev;
  } gpx_det_st_t;
  typedef struct packed {
    logic [`GPX_PIN_W-1:0] latch;
    logic [`GPX_PIN_W-1:0] dir;
    logic [`GPX_PIN_W-1:0] opt;
    gpx_sens_t sens;
    logic pend;
    logic [`GPX_PIN_W-1:0] rdata;
    gpx_pad_t pad;
    logic [`GPX_PIN_W-1:0] alt_in;
    logic irq_req;
    logic wake;
  } gpx_port_st_t;
endpackage

/* hdl/gpx_irq_detect.sv */
// synchroniser and edge or level detector for interrupt pins
`timescale 1ns/100ps
`default_nettype none
`include "gpx_consts.svh"
module gpx_irq_detect
  import gpx_pkg::*;
(
  input wire logic core_clk, // cpu clock
  input wire logic nrst, // sync reset, low
  input wire logic clk_en, // freezes state when low
  input wire logic [`GPX_PIN_W-1:0] pin_in, // raw pin levels
  input wire gpx_sens_t sens, // selected sensitivity
  output logic [`GPX_PIN_W-1:0] event_hit // per pin detected event
);
  gpx_det_st_t st_ff;
  gpx_det_st_t nxt_st;

  // two stage synchroniser, then one stage of history for edges
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync_a = pin_in;
    nxt_st.sync_b = st_ff.sync_a;
    nxt_st.prev = st_ff.sync_b;
  end

  // per pin detection; only the second stage and history are looked at
  always_comb begin
    case (sens)
      GPX_SENS_FALL_LOW: event_hit = ~st_ff.sync_b;
      GPX_SENS_RISE: event_hit = st_ff.sync_b & ~st_ff.prev;
      GPX_SENS_FALL: event_hit = ~st_ff.sync_b & st_ff.prev;
      default: event_hit = st_ff.sync_b ^ st_ff.prev;
    endcase
  end

  // history resets high so a quiet pulled-up pin gives no false edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff <= '1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

/* tb/gpx_port_checker.sv */
// port boundary assertions for the gpio port
`timescale 1ns/100ps
`default_nettype none
`include "gpx_consts.svh"
module gpx_port_checker
  import gpx_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic nrst, // reset, low
  input wire logic clk_en, // enable
  input wire gpx_bus_req_t bus_req, // access
  input wire logic [7:0] rd_data, // read data
  input wire gpx_pad_t pad, // pad drive
  input wire gpx_alt_t alt, // claims
  input wire logic vec_fetch, // fetch
  input wire logic cc_irq_mask, // mask
  input wire logic irq_req, // request
  input wire logic wake // wake
);
  logic clr_req;
  // both ways of dropping a pending request
  assign clr_req = vec_fetch | (bus_req.wr & (bus_req.addr == `GPX_OFF_SENS));
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // a clear taken one edge back explains a falling wake
  sequence s_cleared;
    $past(clr_req);
  endsequence
  a_rd_idle_zero: assert property (clk_en && !bus_req.rd |=> rd_data == 8'h00)
    else $error("rd_data not idle");
  a_irq_mask_gate: assert property ($past(clk_en) |-> irq_req == (wake && !$past(cc_irq_mask)))
    else $error("irq_req disagrees with mask");
  a_pend_holds: assert property (wake && !clr_req |=> wake)
    else $error("request dropped");
  a_clear_cause: assert property ($fell(wake) && $past(nrst) |-> s_cleared)
    else $error("request cleared without cause");
  a_no_pu_driven: assert property ((pad.pu & ~pad.oe_n) == 8'h00)
    else $error("pull-up on driven pin");
  a_no_pu_float: assert property ((pad.pu & `GPX_IRQ_FLT_DEF) == 8'h00)
    else $error("pull-up on floating irq pin");
  a_alt_drives: assert property (clk_en |=> (pad.oe_n & $past(alt.en & ~alt.od)) == 8'h00)
    else $error("peripheral pin not driven");
  a_alt_value: assert property (clk_en |=> ((pad.out ^ $past(alt.out)) & $past(alt.en)) == 8'h00)
    else $error("peripheral value not on pad");
endmodule
bind gpx_port gpx_port_checker u_chk (.core_clk, .nrst, .clk_en, .bus_req, .rd_data, .pad, .alt,
  .vec_fetch, .cc_irq_mask, .irq_req, .wake);
`default_nettype wire

/* tb/gpx_pin_model.sv */
// pads plus far side: resolves the level of each pin
`timescale 1ns/100ps
`default_nettype none
module gpx_pin_model
  import gpx_pkg::*;
(
  input wire logic core_clk, // clock
  input wire gpx_pad_t pad, // design drive
  input wire logic [7:0] ext_en, // far side drives
  input wire logic [7:0] ext_val, // far side level
  output logic [7:0] pin_in // resolved level
);
  logic [7:0] wob_ff;
  initial wob_ff = 8'h55;
  // undriven pins wander so no floating level can be relied on
  always @(posedge core_clk) wob_ff <= ~wob_ff;
  // design drive wins, then far side, then pull-up, else wander
  assign pin_in = (~pad.oe_n & pad.out) | (pad.oe_n & ext_en & ext_val)
    | (pad.oe_n & ~ext_en & (pad.pu | wob_ff));
endmodule
`default_nettype wire

/* tb/tb_gpx_port.sv */
// self-checking bench for the gpio port
`timescale 1ns/100ps
`default_nettype none
`include "gpx_consts.svh"
module tb_gpx_port
  import gpx_pkg::*;
;
  logic core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, vec_fetch = 1'b0, cc_irq_mask = 1'b0;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'hFF, lv, rd_data, pin_in, alt_in;
  logic irq_req, wake;
  gpx_bus_req_t bus_req = '0;
  gpx_alt_t alt = '0;
  gpx_pad_t pad;
  int miscompares = 0, comparisons = 0, cyc = 0;
  gpx_port DUT (.core_clk, .nrst, .clk_en, .bus_req, .rd_data, .pin_in, .pad, .alt, .alt_in,
    .vec_fetch, .cc_irq_mask, .irq_req, .wake);
  gpx_pin_model u_pins (.core_clk, .pad, .ext_en, .ext_val, .pin_in);
  always #20 core_clk = ~core_clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict;
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // values are taken at an edge, before its updates land, so they are settled
  task chk(input string s, input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // one-cycle strobes, dropped on the edge that takes them
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus_req <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) bus_req <= '0;
    // data stand for the cycle after the taking edge; read them at the next edge
    @(posedge core_clk) chk("rd_data", rd_data, e);
  endtask
  task wirq(input logic e);
    int n;
    n = 0;
    while (irq_req !== e && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    chk("irq_req", 8'(irq_req), 8'(e));
  endtask
  task vf;
    @(posedge core_clk) vec_fetch <= 1'b1;
    @(posedge core_clk) vec_fetch <= 1'b0;
  endtask
  initial begin
    tk(3);
    nrst <= 1'b1;
    // cleared registers, unmapped place ignores writes
    wr(8'h04, 8'hFF);
    for (int a = 0; a < 5; a++) rd(8'(a), (a == 0) ? 8'hFF : 8'h00);
    // latch first, then direction and drive type
    wr(8'h00, 8'hA5);
    wr(8'h01, 8'hFF);
    wr(8'h02, 8'hFF);
    ext_en <= 8'h00;
    tk(2);
    chk("pp_oe", pad.oe_n, 8'h00);
    chk("pp_out", pad.out, 8'hA5);
    chk("alt_in", alt_in, 8'hA5);
    rd(8'h00, 8'hA5);
    wr(8'h02, 8'h00);
    tk(2);
    chk("od_oe", pad.oe_n, 8'hA5);
    // pull-up input: pins read back, writes stay in the latch
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hFF);
    ext_en <= 8'hFF;
    ext_val <= 8'h3C;
    tk(2);
    chk("pu", pad.pu, ~(`GPX_IRQ_FLT_DEF));
    chk("alt_in", alt_in, 8'h3C);
    rd(8'h00, 8'h3C);
    wr(8'h00, 8'h11);
    tk(2);
    chk("in_oe", pad.oe_n, 8'hFF);
    // peripheral takes pins 1:0, pin 1 open drain; those pins floating first
    wr(8'h02, 8'hFC);
    alt <= '{8'h03, 8'h03, 8'h02};
    tk(2);
    chk("alt_oe", pad.oe_n & 8'h03, 8'h02);
    chk("alt_out", pad.out & 8'h03, 8'h03);
    rd(8'h00, 8'h3F);
    alt <= '0;
    // pin 3 interrupt under each sensitivity code
    wr(8'h02, 8'h08);
    for (int c = 0; c < 4; c++) begin
      lv = (c == 1) ? 8'h00 : 8'hFF;
      // new sensitivity first: a pin change under the old one would set again
      wr(8'h03, 8'(c));
      ext_val <= lv;
      tk(8);
      chk("idle", 8'(irq_req), 8'h00);
      ext_val <= ~lv;
      wirq(1'b1);
      ext_val <= lv;
      tk(5);
      vf();
      tk(3);
      chk("fetch", 8'(irq_req), 8'h00);
    end
    // rewriting the sensitivity cancels, pin left low
    ext_val <= 8'h00;
    wirq(1'b1);
    wr(8'h03, 8'h02);
    tk(3);
    chk("cancel", 8'(irq_req), 8'h00);
    // a masked request still wakes the device
    ext_val <= 8'hFF;
    cc_irq_mask <= 1'b1;
    tk(4);
    ext_val <= 8'h00;
    tk(8);
    chk("masked", 8'(irq_req), 8'h00);
    chk("wake", 8'(wake), 8'h01);
    cc_irq_mask <= 1'b0;
    wirq(1'b1);
    vf();
    // two sources enabled, pin 7 alone fires
    wr(8'h02, 8'h88);
    ext_val <= 8'hFF;
    tk(4);
    wr(8'h03, 8'h02);
    ext_val <= 8'h7F;
    wirq(1'b1);
    vf();
    // pin 0 has no interrupt capability
    wr(8'h02, 8'h01);
    ext_val <= 8'hFF;
    tk(4);
    wr(8'h03, 8'h02);
    ext_val <= 8'hFE;
    tk(8);
    chk("std", 8'(irq_req), 8'h00);
    // clock enable low: a write in that time is dropped
    clk_en <= 1'b0;
    wr(8'h01, 8'hFF);
    clk_en <= 1'b1;
    rd(8'h01, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
